// ---- hw/sfsa_top.sv ----
// Line write address generator for a camera input path, with its queue.
// Assumes sync and field pins from outside the clock domain, an APB master,
// and a memory writer that drains the address queue at its own pace.
`timescale 1ns/1ps

// Queue with a registered head word, so its drain-side outputs come from flip-flops.
module sfsa_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage behind the head register.
    logic [AW-1:0] wr_ptr_q;  // Next slot to write.
    logic [AW-1:0] rd_ptr_q;  // Next slot to move into the head.
    logic [AW:0] count_q;  // Words held in storage.
    logic head_valid_q;  // Head register holds a word.
    logic [WIDTH-1:0] head_q;  // Word offered to the drain side.

    wire push = in_valid && in_ready;
    wire head_free = !head_valid_q || out_ready;
    wire pop = head_free && (count_q != '0);

    // Full looks at storage only: a word in the head register never counts toward it.
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = head_valid_q;
    assign out_data = head_q;

    // Storage write port; no reset needed for the data itself.
    always_ff @(posedge mclk)
    begin
        if (ce && push)
        begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and count move on push and pop.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else if (ce)
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Head register refills whenever it is free and storage has a word.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            head_valid_q <= 1'b0;
            head_q <= '0;
        end
        else if (ce)
        begin
            if (pop)
            begin
                head_valid_q <= 1'b1;
                head_q <= mem[rd_ptr_q];
            end
            else if (out_ready)
            begin
                head_valid_q <= 1'b0;
            end
        end
    end
endmodule

// Top level: APB registers, pin synchronisers and the address generator.
module sfsa_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vertical_sync,
    input wire logic line_sync,
    input wire logic field_id,
    output logic line_valid,
    input wire logic line_ready,
    output sfsa_pkg::sfsa_line_t line_out
);
    // Turns a three-bit step code into a signed count of lines.
    function automatic logic signed [3:0] step_lines(input logic [2:0] code);
        begin
            // Codes 4 to 7 walk backward one to four lines.
            if (code[2])
                step_lines = 4'sd3 - $signed({1'b0, code});
            else
                step_lines = $signed({1'b0, code}) + 4'sd1;
        end
    endfunction

    // Software-visible registers.
    logic [sfsa_pkg::SFSA_STEP_W-1:0] step_cfg_q;  // Line step settings.
    logic [31:sfsa_pkg::SFSA_ALIGN] start_q;  // Frame start, low bits gone.
    logic [sfsa_pkg::SFSA_PITCH_W-1:sfsa_pkg::SFSA_ALIGN] pitch_q;
    logic overflow_q;  // A line arrived while the last one still waited.

    // APB answer registers.
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // Synchronisers for the three pins, and their filtered levels.
    logic [2:0] sync_s1_q;
    logic [2:0] sync_s2_q;
    logic [2:0] sync_s3_q;
    logic [2:0] pin_q;  // Accepted levels: vsync, line sync, field.
    logic [2:0] pin_prev_q;

    // Frame state.
    sfsa_pkg::sfsa_state_t state_q;
    sfsa_pkg::sfsa_cfg_t shadow_q;  // Settings for the frame in progress.
    logic field_q;  // Field of the frame in progress, after inversion.
    logic first_q;  // Next line is the first of the frame.
    logic odd_q;  // Parity of the last line stored.
    logic [31:0] cur_addr_q;  // Address of the last line stored.
    logic [sfsa_pkg::SFSA_LINE_W-1:0] line_cnt_q;
    logic pend_q;  // A line address waits for room in the queue.
    sfsa_pkg::sfsa_line_t pend_q_data;

    // Queue hand-off.
    logic fifo_in_ready;

    // Decoding of the bus request.
    wire setup = psel && !penable;
    wire wr_take = psel && penable && pready_q && pwrite;
    wire hit_step = (paddr == sfsa_pkg::SFSA_OFS_STEP);
    wire hit_start = (paddr == sfsa_pkg::SFSA_OFS_START);
    wire hit_pitch = (paddr == sfsa_pkg::SFSA_OFS_PITCH);
    wire hit_status = (paddr == sfsa_pkg::SFSA_OFS_STATUS);
    wire hit_cur = (paddr == sfsa_pkg::SFSA_OFS_CURADDR);
    wire hit_any = hit_step || hit_start || hit_pitch || hit_status || hit_cur;

    // Read mux; reserved and ignored bits read as zero.
    logic [31:0] status_word;
    logic [31:0] rd_word;
    assign status_word = {1'b0, line_cnt_q, 13'h0000,
                          (state_q == sfsa_pkg::SFSA_IN_FRAME),
                          field_q, overflow_q};
    assign rd_word = hit_step ? {17'h00000, step_cfg_q} :
                     hit_start ? {start_q, 5'h00} :
                     hit_pitch ? {16'h0000, pitch_q, 5'h00} :
                     hit_status ? status_word :
                     hit_cur ? cur_addr_q :
                     32'h0000_0000;

    // Events seen on the filtered pins.
    wire vs_rise = pin_q[0] && !pin_prev_q[0];
    wire ls_rise = pin_q[1] && !pin_prev_q[1];

    // Settings that would be captured by a vertical sync in this cycle.
    sfsa_pkg::sfsa_cfg_t next_cfg;
    assign next_cfg.field_id_invert = step_cfg_q[sfsa_pkg::SFSA_POS_FINV];
    assign next_cfg.second_field_line_offset =
        step_cfg_q[sfsa_pkg::SFSA_POS_FOFS +: 2];
    assign next_cfg.step_even_line_field0 =
        step_cfg_q[sfsa_pkg::SFSA_POS_EVEN0 +: 3];
    assign next_cfg.step_odd_line_field0 =
        step_cfg_q[sfsa_pkg::SFSA_POS_ODD0 +: 3];
    assign next_cfg.step_even_line_field1 =
        step_cfg_q[sfsa_pkg::SFSA_POS_EVEN1 +: 3];
    assign next_cfg.step_odd_line_field1 =
        step_cfg_q[sfsa_pkg::SFSA_POS_ODD1 +: 3];
    assign next_cfg.frame_start_address = start_q;
    assign next_cfg.line_pitch = pitch_q;

    // Step after the last line, chosen by field and line parity.
    logic [2:0] step_code;
    assign step_code = !field_q ?
        (odd_q ? shadow_q.step_odd_line_field0
               : shadow_q.step_even_line_field0) :
        (odd_q ? shadow_q.step_odd_line_field1
               : shadow_q.step_even_line_field1);

    // One pitch is a multiple of 32 bytes since its low bits are dropped.
    logic signed [16:0] pitch_s;
    logic signed [20:0] step_delta;
    logic signed [20:0] field_delta;
    logic [31:0] first_addr;
    logic [31:0] next_addr;
    assign pitch_s = $signed({1'b0, shadow_q.line_pitch, 5'h00});
    assign step_delta = step_lines(step_code) * pitch_s;
    assign field_delta = $signed({2'b00, shadow_q.second_field_line_offset})
                         + 21'sd1;
    assign first_addr = {shadow_q.frame_start_address, 5'h00} +
        (field_q ? 32'(field_delta * pitch_s) : 32'h0000_0000);
    assign next_addr = first_q ? first_addr :
        cur_addr_q + {{11{step_delta[20]}}, step_delta};

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // APB answer: read data and ready are prepared in the setup cycle.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else if (ce)
        begin
            pready_q <= setup;
            pslverr_q <= setup && !hit_any;
            prdata_q <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Register writes; the shadow copy keeps them out of the current frame.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            step_cfg_q <= sfsa_pkg::SFSA_RST_STEP[sfsa_pkg::SFSA_STEP_W-1:0];
            start_q <= sfsa_pkg::SFSA_RST_START[31:sfsa_pkg::SFSA_ALIGN];
            pitch_q <= sfsa_pkg::SFSA_RST_PITCH[15:sfsa_pkg::SFSA_ALIGN];
        end
        else if (ce && wr_take)
        begin
            if (hit_step)
                step_cfg_q <= pwdata[sfsa_pkg::SFSA_STEP_W-1:0];
            else if (hit_start)
                start_q <= pwdata[31:sfsa_pkg::SFSA_ALIGN];
            else if (hit_pitch)
                pitch_q <= pwdata[15:sfsa_pkg::SFSA_ALIGN];
        end
    end

    // Pins pass three flops; a level counts once stages two and three agree.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync_s1_q <= 3'h0;
            sync_s2_q <= 3'h0;
            sync_s3_q <= 3'h0;
            pin_q <= 3'h0;
            pin_prev_q <= 3'h0;
        end
        else if (ce)
        begin
            sync_s1_q <= {field_id, line_sync, vertical_sync};
            sync_s2_q <= sync_s1_q;
            sync_s3_q <= sync_s2_q;
            for (int i = 0; i < 3; i++)
            begin
                if (sync_s2_q[i] == sync_s3_q[i])
                    pin_q[i] <= sync_s3_q[i];
            end
            pin_prev_q <= pin_q;
        end
    end

    // Frame and line sequencing.
    // A vertical sync wins over a line sync in the same cycle.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= sfsa_pkg::SFSA_WAIT_FRAME;
            shadow_q <= '0;
            field_q <= 1'b0;
            first_q <= 1'b1;
            odd_q <= 1'b0;
            cur_addr_q <= 32'h0000_0000;
            line_cnt_q <= '0;
        end
        else if (ce)
        begin
            if (vs_rise)
            begin
                state_q <= sfsa_pkg::SFSA_IN_FRAME;
                shadow_q <= next_cfg;
                field_q <= pin_q[2] ^ next_cfg.field_id_invert;
                first_q <= 1'b1;
                odd_q <= 1'b0;
                line_cnt_q <= '0;
            end
            else
            begin
                case (state_q)
                    sfsa_pkg::SFSA_IN_FRAME:
                    begin
                        // A line is stored only when its slot is free.
                        if (ls_rise && !pend_q)
                        begin
                            cur_addr_q <= next_addr;
                            odd_q <= first_q ? 1'b0 : !odd_q;
                            first_q <= 1'b0;
                            line_cnt_q <= line_cnt_q + 1'b1;
                        end
                    end
                    default:
                    begin
                        // Lines before the first sync have no frame.
                        state_q <= sfsa_pkg::SFSA_WAIT_FRAME;
                    end
                endcase
            end
        end
    end

    // Hand-off slot toward the queue; it stalls while the queue is full.
    wire line_take = ls_rise && !vs_rise && !pend_q &&
                     (state_q == sfsa_pkg::SFSA_IN_FRAME);
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pend_q <= 1'b0;
            pend_q_data <= '0;
        end
        else if (ce)
        begin
            if (line_take)
            begin
                pend_q <= 1'b1;
                pend_q_data.addr <= next_addr;
                pend_q_data.field <= field_q;
                pend_q_data.line <= line_cnt_q;
            end
            else if (fifo_in_ready)
            begin
                pend_q <= 1'b0;
            end
        end
    end

    // Lost-line flag: set wins over the write-one clear.
    wire ovf_set = ls_rise && !vs_rise && pend_q &&
                   (state_q == sfsa_pkg::SFSA_IN_FRAME);
    wire ovf_clr = wr_take && hit_status && pwdata[sfsa_pkg::SFSA_POS_OVF];
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            overflow_q <= 1'b0;
        else if (ce)
            overflow_q <= ovf_set || (overflow_q && !ovf_clr);
    end

    // The address queue; its head register drives the stream outputs.
    sfsa_fifo #(
        .WIDTH($bits(sfsa_pkg::sfsa_line_t)),
        .DEPTH(sfsa_pkg::SFSA_FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .in_valid(pend_q),
        .in_ready(fifo_in_ready),
        .in_data(pend_q_data),
        .out_valid(line_valid),
        .out_ready(line_ready),
        .out_data(line_out)
    );
endmodule

// ---- hw/sfsa_pkg.sv ----
// Shared constants and carrier types for the frame line address generator.
// Assumes an APB register bus with 32-bit data and one clock domain.
package sfsa_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] SFSA_OFS_STEP = 8'h00;
    localparam logic [7:0] SFSA_OFS_START = 8'h04;
    localparam logic [7:0] SFSA_OFS_PITCH = 8'h08;
    localparam logic [7:0] SFSA_OFS_STATUS = 8'h0c;
    localparam logic [7:0] SFSA_OFS_CURADDR = 8'h10;

    // Field positions in the line step configuration register.
    localparam int SFSA_POS_FINV = 14;
    localparam int SFSA_POS_FOFS = 12;
    localparam int SFSA_POS_EVEN0 = 9;
    localparam int SFSA_POS_ODD0 = 6;
    localparam int SFSA_POS_EVEN1 = 3;
    localparam int SFSA_POS_ODD1 = 0;

    // Writable width of the line step register, alignment of addresses and width of the pitch register.
    localparam int SFSA_STEP_W = 15;
    localparam int SFSA_ALIGN = 5;
    localparam int SFSA_PITCH_W = 16;

    // Status register bit positions.
    localparam int SFSA_POS_OVF = 0;
    localparam int SFSA_POS_FIELD = 1;
    localparam int SFSA_POS_ACTIVE = 2;
    localparam int SFSA_POS_LINE = 16;

    // Reset values.
    localparam logic [31:0] SFSA_RST_STEP = 32'h0000_0000;
    localparam logic [31:0] SFSA_RST_START = 32'h0000_0000;
    localparam logic [31:0] SFSA_RST_PITCH = 32'h0000_0000;

    // Depth of the address queue and width of the line number.
    localparam int SFSA_FIFO_DEPTH = 32;
    localparam int SFSA_LINE_W = 15;

    // Frame settings that take effect together at the vertical sync.
    typedef struct packed {
        logic field_id_invert;
        logic [1:0] second_field_line_offset;
        logic [2:0] step_even_line_field0;
        logic [2:0] step_odd_line_field0;
        logic [2:0] step_even_line_field1;
        logic [2:0] step_odd_line_field1;
        logic [31:SFSA_ALIGN] frame_start_address;
        logic [SFSA_PITCH_W-1:SFSA_ALIGN] line_pitch;
    } sfsa_cfg_t;

    // One entry of the outgoing address stream.
    typedef struct packed {
        logic [31:0] addr;
        logic field;
        logic [SFSA_LINE_W-1:0] line;
    } sfsa_line_t;

    // Control states of the generator, one-hot.
    typedef enum logic [1:0] {
        SFSA_WAIT_FRAME = 2'b01,
        SFSA_IN_FRAME = 2'b10
    } sfsa_state_t;

endpackage

// ---- bench/sfsa_properties.sv ----
// Port checker for the line address generator.
// Assumes one clock domain, rst active high, and ce low only while idle.
`timescale 1ns/1ps
module sfsa_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic vertical_sync,
    input wire logic line_sync,
    input wire logic field_id,
    input wire logic line_valid,
    input wire logic line_ready,
    input wire sfsa_pkg::sfsa_line_t line_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // A setup cycle is answered in the next cycle, without waits.
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    // The answer lasts one cycle only.
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready held too long");
    // An error code only travels with an answer.
    AST_ERR_WITH_READY: assert property (pslverr |-> pready && penable)
        else $error("pslverr without pready");
    // Addresses past the map are refused and read as zero.
    AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h10
        |=> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    AST_START_LOW: assert property (pready && !pwrite &&
        paddr == sfsa_pkg::SFSA_OFS_START |-> prdata[4:0] == 5'h0)
        else $error("start address low bits not zero");
    // Reserved upper bits of the step register read as zero.
    AST_STEP_RSVD: assert property (pready && !pwrite &&
        paddr == sfsa_pkg::SFSA_OFS_STEP |-> prdata[31:15] == 17'h0)
        else $error("step register reserved bits set");
    // An offered line is held until taken, so no address is skipped.
    AST_LINE_HOLD: assert property (line_valid && !line_ready
        |=> line_valid && $stable(line_out))
        else $error("line offer changed before taken");
    AST_ADDR_ALIGN: assert property (line_valid |->
        line_out.addr[4:0] == 5'h0)
        else $error("line address not 32-byte aligned");
    // A new offer only rises when, two cycles before, the head was empty or was taken by the drain side.
    AST_LINE_CAUSE: assert property ($rose(line_valid)
        |-> $past(line_valid, 2) == 1'b0 || $past(line_ready, 2))
        else $error("line offered without cause");
    COV_READ_ERR: cover property (pslverr && !pwrite);
    COV_STALL: cover property ((line_valid && !line_ready) [*3]);
    COV_TAKE: cover property (line_valid && line_ready);
endmodule
bind sfsa_top sfsa_properties i_props (.mclk(mclk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vertical_sync(vertical_sync), .line_sync(line_sync),
    .field_id(field_id), .line_valid(line_valid),
    .line_ready(line_ready), .line_out(line_out));

// ---- bench/sfsa_mem_model.sv ----
// Memory writer model that drains the line address stream.
// Assumes the bench changes stall and slow only between bursts.
`timescale 1ns/1ps
module sfsa_mem_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic stall,
    input wire logic slow,
    input wire logic line_valid,
    input wire sfsa_pkg::sfsa_line_t line_out,
    output logic line_ready
);
    // Lines taken, in order, for the bench to inspect.
    sfsa_pkg::sfsa_line_t got[$];
    logic tick_q;
    // Ready drops while stalled, and every other cycle when slow.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            line_ready <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            if (line_valid && line_ready)
            begin
                got.push_back(line_out);
            end
            tick_q <= ~tick_q;
            line_ready <= !stall && (!slow || tick_q);
        end
    end
endmodule

// ---- bench/sensor_frame_sdram_addressing_test.sv ----
// Self-checking bench for the line address generator.
// Assumes the design files are compiled first; ce stays high except during one line sync pulse.
`timescale 1ns/1ps
module sensor_frame_sdram_addressing_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic vertical_sync = 1'b0;
    logic line_sync = 1'b0;
    logic field_id = 1'b0;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic line_valid;
    logic line_ready;
    sfsa_pkg::sfsa_line_t line_out;
    int err_count = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic er;
    always #12.5 mclk = ~mclk;
    sfsa_top i_dut (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vertical_sync(vertical_sync),
        .line_sync(line_sync), .field_id(field_id),
        .line_valid(line_valid), .line_ready(line_ready),
        .line_out(line_out));
    sfsa_mem_model i_mem (.mclk(mclk), .rst(rst), .stall(stall),
        .slow(slow), .line_valid(line_valid), .line_out(line_out),
        .line_ready(line_ready));
    // Prints the counts and the verdict, then ends the run.
    task close_out;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer after an idle edge, so psel is never set twice in
    // one time step; the wait for pready is bounded.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        if (k >= 20)
        begin
            err_count++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pulse a sync pin wide enough for the synchronisers.
    task pulse(input logic vs);
        if (vs)
            vertical_sync <= 1'b1;
        else
            line_sync <= 1'b1;
        repeat (5) @(posedge mclk);
        vertical_sync <= 1'b0;
        line_sync <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    task wait_got(input int n);
        int k;
        for (k = 0; k < 600 && i_mem.got.size() < n; k++)
            @(posedge mclk);
        if (k >= 600)
        begin
            err_count++;
            close_out();
        end
    endtask
    function automatic logic [31:0] st(input logic [2:0] c);
        return c < 3'h4 ? 32'(c) + 32'h1 : 32'h3 - 32'(c);
    endfunction
    task regs_check;
        apb(1'b0, sfsa_pkg::SFSA_OFS_START, 32'h0);
        chk("start reset", rd, 32'h0);
        apb(1'b1, sfsa_pkg::SFSA_OFS_START, 32'h1234_567f);
        apb(1'b0, sfsa_pkg::SFSA_OFS_START, 32'h0);
        chk("start read", rd, 32'h1234_5660);
        apb(1'b1, sfsa_pkg::SFSA_OFS_STEP, 32'hffff_ffff);
        apb(1'b0, sfsa_pkg::SFSA_OFS_STEP, 32'h0);
        chk("step read", rd, 32'h0000_7fff);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
    endtask
    // Step codes in all four fields, every field offset, both field flags.
    task frames;
        logic [31:0] a[3];
        logic [2:0] ev;
        logic [2:0] od;
        logic f;
        for (int c = 0; c < 8; c++)
        begin
            f = c[1] ^ c[0];
            ev = f ? 3'(c + 2) : 3'(c);
            od = f ? 3'(c + 3) : 3'(c + 1);
            apb(1'b1, sfsa_pkg::SFSA_OFS_STEP, {17'h0, c[0], c[2], c[0],
                3'(c), 3'(c + 1), 3'(c + 2), 3'(c + 3)});
            apb(1'b1, sfsa_pkg::SFSA_OFS_START, 32'h0001_001f);
            apb(1'b1, sfsa_pkg::SFSA_OFS_PITCH, 32'h0000_00ff);
            field_id <= c[1];
            pulse(1'b1);
            pulse(1'b0);
            wait_got(1);
            apb(1'b1, sfsa_pkg::SFSA_OFS_START, 32'h00ff_0000);
            apb(1'b1, sfsa_pkg::SFSA_OFS_STEP, 32'h0);
            pulse(1'b0);
            pulse(1'b0);
            wait_got(3);
            a[0] = 32'h0001_0000 +
                (f ? (32'({c[2], c[0]}) + 32'h1) * 32'he0 : 32'h0);
            a[1] = a[0] + st(ev) * 32'he0;
            a[2] = a[1] + st(od) * 32'he0;
            for (int n = 0; n < 3; n++)
            begin
                chk("addr", i_mem.got[n].addr, a[n]);
                chk("field", 32'(i_mem.got[n].field), 32'(f));
                chk("line", 32'(i_mem.got[n].line), 32'(n));
            end
            apb(1'b0, sfsa_pkg::SFSA_OFS_STATUS, 32'h0);
            chk("status field", 32'(rd[1]), 32'(f));
            i_mem.got.delete();
        end
    endtask
    // Fill the queue with the drain stalled, then drain it slowly.
    // Queue, head and hand-off slot hold 34 lines; the last two are lost.
    task fill_drain;
        stall <= 1'b1;
        field_id <= 1'b0;
        apb(1'b1, sfsa_pkg::SFSA_OFS_START, 32'h0000_2000);
        apb(1'b1, sfsa_pkg::SFSA_OFS_PITCH, 32'h0000_0040);
        pulse(1'b1);
        repeat (36) pulse(1'b0);
        apb(1'b0, sfsa_pkg::SFSA_OFS_STATUS, 32'h0);
        chk("lost flag", 32'(rd[0]), 32'h1);
        slow <= 1'b1;
        stall <= 1'b0;
        wait_got(34);
        repeat (40) @(posedge mclk);
        chk("drained", 32'(i_mem.got.size()), 32'd34);
        chk("last addr", i_mem.got[33].addr, 32'h0000_2840);
        apb(1'b1, sfsa_pkg::SFSA_OFS_STATUS, 32'h1);
        apb(1'b0, sfsa_pkg::SFSA_OFS_STATUS, 32'h0);
        chk("lost clear", 32'(rd[0]), 32'h0);
        // A line sync while the clock enable is low must leave no trace.
        ce <= 1'b0;
        pulse(1'b0);
        ce <= 1'b1;
        repeat (20) @(posedge mclk);
        chk("frozen", 32'(i_mem.got.size()), 32'd34);
    endtask
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        regs_check();
        frames();
        fill_drain();
        close_out();
    end
endmodule
